// ---- hdl/user_command_sequencer.sv ----
// User command string store, download, read-back and sequenced execution.
// What this block does
// - Stores one user command string of up to 250 characters loaded from the host.
// - When enabled, an accepted master read press runs the stored string.
// - The string runs only in auto read mode, never in step or manual mode.
// - A press runs the string only while the user command enable switch is on.
// - With the cold start switch off the stored string survives reset.
// - In cold start the stored string is discarded on every reset.
// - Commas split the string so each press runs only the next substring.
// - Characters after the load command up to carriage return become the string.
// - The read-back command returns the stored string to the host.
// - A pause command waits its numeric argument in milliseconds.
// - Channel reads, read-all and pauses run strictly in order.
`timescale 1ns/1ps
module user_command_sequencer #(
   parameter int DEPTH = user_cmd_pkg::MAX_CHARS,
   parameter int CYCLES_MS = user_cmd_pkg::CYCLES_PER_MS
)(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic clkEn,
   input wire logic coldStart,
   input wire logic userCmdEnable,
   input wire logic [1:0] readMode,
   input wire logic readPress,
   input wire logic [7:0] rxData,
   input wire logic rxValid,
   output logic [7:0] txData,
   output logic txValid,
   input wire logic txReady,
   output logic [7:0] chanId,
   output logic chanRead,
   output logic readAll,
   input wire logic gageDone,
   output logic running
);
   initial
   begin
      if (DEPTH < 1 || DEPTH > 254)
         $error("DEPTH must lie in 1 to 254");
   end
   logic [7:0] mem [0:DEPTH-1];
   logic [7:0] len;
   logic [7:0] rdPtr;
   logic [7:0] startPtr;
   logic [7:0] cmdChar;
   logic [15:0] argVal;
   logic [1:0] rxPhase;
   logic loading;
   logic readbackReq;
   logic tmrStart;
   logic tmrBusy;
   logic issueAll;
   logic wasReset;
   user_cmd_pkg::run_state_t state;
   wire [7:0] curChar = mem[rdPtr];
   wire atEnd = (rdPtr >= len);
   wire isDigit = !atEnd && curChar >= user_cmd_pkg::CHAR_0 && curChar <= user_cmd_pkg::CHAR_9;
   wire trigger = readPress && userCmdEnable && (readMode == user_cmd_pkg::MODE_AUTO)
      && (len != 8'h00);
   wire [15:0] digitVal = {8'h00, curChar - user_cmd_pkg::CHAR_0};
   wire [15:0] next_arg = 16'((argVal << 3) + (argVal << 1) + digitVal);
   wire cmdByte = rxValid && !loading && (rxPhase == 2'h2);
   ms_timer #(.CYCLES_MS(CYCLES_MS)) pauseTimer (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .clkEn(clkEn),
      .start(tmrStart),
      .msCount(argVal),
      .busy(tmrBusy)
   );
   always_ff @(posedge sys_clk)
   begin
      if (clkEn && loading && rxValid && rxData != user_cmd_pkg::CHAR_CR && len < 8'(DEPTH))
         mem[len] <= rxData;
   end
   // Host command parsing and download mode flag.
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rxPhase <= 2'h0;
         loading <= 1'b0;
         readbackReq <= 1'b0;
         wasReset <= 1'b1;
      end
      else if (clkEn)
      begin
         wasReset <= 1'b0;
         readbackReq <= 1'b0;
         if (loading)
         begin
            if (rxValid && rxData == user_cmd_pkg::CHAR_CR)
               loading <= 1'b0;
         end
         else if (rxValid)
         begin
            if (rxData == user_cmd_pkg::CHAR_LT)
               rxPhase <= 2'h1;
            else if (rxPhase == 2'h1 && rxData == user_cmd_pkg::CHAR_U)
               rxPhase <= 2'h2;
            else
               rxPhase <= 2'h0;
            if (cmdByte && rxData == user_cmd_pkg::CHAR_S)
               loading <= 1'b1;
            if (cmdByte && rxData == user_cmd_pkg::CHAR_R)
               readbackReq <= 1'b1;
         end
      end
   end
   // length kept on warm start and cleared on cold start.
   always_ff @(posedge sys_clk)
   begin
      if (clkEn)
      begin
         if (wasReset && coldStart)
            len <= 8'h00;
         else if (cmdByte && rxData == user_cmd_pkg::CHAR_S)
            len <= 8'h00;
         else if (loading && rxValid && rxData != user_cmd_pkg::CHAR_CR && len < 8'(DEPTH))
            len <= len + 8'h01;
      end
   end
   assign running = (state != user_cmd_pkg::IDLE) && (state != user_cmd_pkg::READBACK);
   assign tmrStart = clkEn && (state == user_cmd_pkg::ARG) && !isDigit;
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state <= user_cmd_pkg::IDLE;
         rdPtr <= 8'h00;
         startPtr <= 8'h00;
         cmdChar <= 8'h00;
         argVal <= 16'h0000;
         chanId <= 8'h00;
         chanRead <= 1'b0;
         readAll <= 1'b0;
         issueAll <= 1'b0;
         txData <= 8'h00;
         txValid <= 1'b0;
      end
      else if (clkEn)
      begin
         chanRead <= 1'b0;
         readAll <= 1'b0;
         case (state)
            user_cmd_pkg::IDLE:
            begin
               if (readbackReq)
               begin
                  rdPtr <= 8'h00;
                  state <= user_cmd_pkg::READBACK;
               end
               else if (trigger)
               begin
                  rdPtr <= (startPtr >= len) ? 8'h00 : startPtr;
                  state <= user_cmd_pkg::FETCH;
               end
            end
            user_cmd_pkg::FETCH:
            begin
               if (atEnd)
               begin
                  startPtr <= 8'h00;
                  state <= user_cmd_pkg::IDLE;
               end
               else if (curChar == user_cmd_pkg::CHAR_COMMA)
               begin
                  startPtr <= rdPtr + 8'h01;
                  state <= user_cmd_pkg::IDLE;
               end
               else
               begin
                  if (curChar == user_cmd_pkg::CHAR_LT)
                     state <= user_cmd_pkg::CMD;
                  rdPtr <= rdPtr + 8'h01;
               end
            end
            user_cmd_pkg::CMD:
            begin
               cmdChar <= curChar;
               argVal <= 16'h0000;
               rdPtr <= rdPtr + 8'h01;
               state <= atEnd ? user_cmd_pkg::FETCH : user_cmd_pkg::ARG;
            end
            user_cmd_pkg::ARG:
            begin
               if (cmdChar == user_cmd_pkg::CHAR_Q)
               begin
                  if (isDigit && !atEnd)
                  begin
                     argVal <= next_arg;
                     rdPtr <= rdPtr + 8'h01;
                  end
                  else
                     state <= user_cmd_pkg::PAUSE;
               end
               else if (cmdChar == user_cmd_pkg::CHAR_R && !atEnd)
               begin
                  issueAll <= (curChar == user_cmd_pkg::CHAR_STAR);
                  chanId <= curChar;
                  rdPtr <= rdPtr + 8'h01;
                  state <= user_cmd_pkg::ISSUE;
               end
               else
                  state <= user_cmd_pkg::FETCH;
            end
            user_cmd_pkg::PAUSE:
            begin
               if (!tmrBusy)
                  state <= user_cmd_pkg::FETCH;
            end
            user_cmd_pkg::ISSUE:
            begin
               chanRead <= !issueAll;
               readAll <= issueAll;
               state <= user_cmd_pkg::WAITDONE;
            end
            user_cmd_pkg::WAITDONE:
            begin
               if (gageDone)
                  state <= user_cmd_pkg::FETCH;
            end
            user_cmd_pkg::READBACK:
            begin
               if (!txValid || txReady)
               begin
                  if (rdPtr < len)
                  begin
                     txData <= curChar;
                     txValid <= 1'b1;
                     rdPtr <= rdPtr + 8'h01;
                  end
                  else if (rdPtr == len)
                  begin
                     txData <= user_cmd_pkg::CHAR_CR;
                     txValid <= 1'b1;
                     rdPtr <= rdPtr + 8'h01;
                  end
                  else
                  begin
                     txValid <= 1'b0;
                     state <= user_cmd_pkg::IDLE;
                  end
               end
            end
            default:
               state <= user_cmd_pkg::IDLE;
         endcase
      end
   end
   a_mode_gate: assert property (@(posedge sys_clk) disable iff (!rstn)
      (state == user_cmd_pkg::IDLE && clkEn && !readbackReq && readPress
       && readMode != user_cmd_pkg::MODE_AUTO) |=> state == user_cmd_pkg::IDLE)
      else $error("String started outside auto mode");
   a_enable_gate: assert property (@(posedge sys_clk) disable iff (!rstn)
      (state == user_cmd_pkg::IDLE && clkEn && !readbackReq && !userCmdEnable)
      |=> state == user_cmd_pkg::IDLE)
      else $error("String started while disabled");
   a_press_start: assert property (@(posedge sys_clk) disable iff (!rstn)
      (state == user_cmd_pkg::IDLE && clkEn && !readbackReq && trigger)
      |=> state == user_cmd_pkg::FETCH)
      else $error("Accepted press did not start the string");
   a_len_bound: assert property (@(posedge sys_clk) disable iff (!rstn)
      len <= 8'(DEPTH))
      else $error("Stored length exceeds capacity");
   a_cold_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
      (clkEn && wasReset && coldStart) |=> len == 8'h00)
      else $error("Cold start kept the string");
   a_comma_stop: assert property (@(posedge sys_clk) disable iff (!rstn)
      (clkEn && state == user_cmd_pkg::FETCH && !atEnd && curChar == user_cmd_pkg::CHAR_COMMA)
      |=> state == user_cmd_pkg::IDLE && startPtr == $past(rdPtr) + 8'h01)
      else $error("Comma did not end the substring");
   a_pause_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
      (clkEn && state == user_cmd_pkg::PAUSE && tmrBusy) |=> state == user_cmd_pkg::PAUSE)
      else $error("Pause ended early");
   // one read request at a time.
   a_read_order: assert property (@(posedge sys_clk) disable iff (!rstn)
      (chanRead || readAll) |-> state == user_cmd_pkg::WAITDONE && !(chanRead && readAll))
      else $error("Read request out of sequence");
   a_readback_cr: assert property (@(posedge sys_clk) disable iff (!rstn)
      (clkEn && state == user_cmd_pkg::READBACK && (!txValid || txReady) && rdPtr == len)
      |=> txValid && txData == user_cmd_pkg::CHAR_CR)
      else $error("Read-back lacks terminator");
endmodule

// ---- hdl/user_cmd_pkg.sv ----
// Constants and types shared by the user command sequencer.
package user_cmd_pkg;
   localparam int MAX_CHARS = 250;
   localparam logic [7:0] CHAR_LT = 8'h3C;
   localparam logic [7:0] CHAR_CR = 8'h0D;
   localparam logic [7:0] CHAR_COMMA = 8'h2C;
   localparam logic [7:0] CHAR_STAR = 8'h2A;
   localparam logic [7:0] CHAR_U = 8'h55;
   localparam logic [7:0] CHAR_S = 8'h53;
   localparam logic [7:0] CHAR_R = 8'h52;
   localparam logic [7:0] CHAR_Q = 8'h51;
   localparam logic [7:0] CHAR_0 = 8'h30;
   localparam logic [7:0] CHAR_9 = 8'h39;
   localparam int CLK_MHZ = 250;
   localparam int PAUSE_UNIT_US = 1000;
   localparam int CYCLES_PER_MS = CLK_MHZ * PAUSE_UNIT_US;
   localparam logic [1:0] MODE_STEP = 2'h0;
   localparam logic [1:0] MODE_MANUAL = 2'h1;
   localparam logic [1:0] MODE_AUTO = 2'h2;
   typedef enum {IDLE, FETCH, CMD, ARG, PAUSE, ISSUE, WAITDONE, READBACK} run_state_t;
endpackage

// ---- hdl/ms_timer.sv ----
// Millisecond pause timer counting a loaded number of milliseconds.
`timescale 1ns/1ps
module ms_timer #(
   parameter int CYCLES_MS = user_cmd_pkg::CYCLES_PER_MS
)(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic clkEn,
   input wire logic start,
   input wire logic [15:0] msCount,
   output logic busy
);
   initial
   begin
      if (CYCLES_MS < 1)
         $error("CYCLES_MS must be at least one");
   end
   logic [31:0] cyc;
   logic [15:0] ms;
   wire lastCyc = (cyc == 32'(CYCLES_MS - 1));
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cyc <= '0;
         ms <= '0;
         busy <= 1'b0;
      end
      else if (clkEn)
      begin
         if (start)
         begin
            cyc <= '0;
            ms <= msCount;
            busy <= (msCount != 16'h0000);
         end
         else if (busy)
         begin
            cyc <= lastCyc ? '0 : cyc + 32'h1;
            if (lastCyc)
            begin
               ms <= ms - 16'h1;
               busy <= (ms != 16'h0001);
            end
         end
      end
   end
endmodule

// ---- verification/host_model.sv ----
// Host side model that sends command bytes and takes read-back characters.
`timescale 1ns/1ps
module host_model (
   input wire logic sys_clk,
   input wire logic slow,
   input wire logic [7:0] txData,
   input wire logic txValid,
   output logic [7:0] rxData,
   output logic rxValid,
   output logic txReady
);
   logic [7:0] got[$];
   logic phase;
   initial
   begin
      rxData = 8'hFF;
      rxValid = 1'b0;
      txReady = 1'b0;
      phase = 1'b0;
   end
   // Takes a character when ready; stalls every other cycle when slow.
   always @(negedge sys_clk)
   begin
      phase = ~phase;
      txReady = ~slow | phase;
      if (txValid === 1'b1 && txReady)
         got.push_back(txData);
   end
   // Sends one byte, then shows its inverse on the idle line.
   task automatic sendByte(input logic [7:0] b);
      @(negedge sys_clk);
      rxData = b;
      rxValid = 1'b1;
      @(negedge sys_clk);
      rxValid = 1'b0;
      rxData = ~b;
   endtask
   task automatic sendStr(input string s, input logic withCr);
      for (int i = 0; i < s.len(); i++)
         sendByte(s[i]);
      if (withCr)
         sendByte(user_cmd_pkg::CHAR_CR);
   endtask
endmodule

// ---- verification/test_user_command_sequencer.sv ----
// Self-checking bench for the user command sequencer.
`timescale 1ns/1ps
module test_user_command_sequencer;
   localparam int MS = 10;
   logic sys_clk, rstn, clkEn, coldStart, userCmdEnable, readPress, gageDone, slow;
   logic [1:0] readMode;
   logic [7:0] rxData, txData, chanId;
   logic rxValid, txValid, txReady, chanRead, readAll, running;
   int bad_count = 0;
   int checks_done = 0;
   int n;
   int hold = 0;
   user_command_sequencer #(.CYCLES_MS(MS)) uut (.sys_clk(sys_clk), .rstn(rstn), .clkEn(clkEn),
      .coldStart(coldStart), .userCmdEnable(userCmdEnable), .readMode(readMode),
      .readPress(readPress), .rxData(rxData), .rxValid(rxValid), .txData(txData),
      .txValid(txValid), .txReady(txReady), .chanId(chanId), .chanRead(chanRead),
      .readAll(readAll), .gageDone(gageDone), .running(running));
   host_model host (.sys_clk(sys_clk), .slow(slow), .txData(txData), .txValid(txValid),
      .rxData(rxData), .rxValid(rxValid), .txReady(txReady));
   initial
   begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic doReset(input logic cold);
      @(negedge sys_clk);
      coldStart = cold;
      rstn = 1'b0;
      repeat (2) @(negedge sys_clk);
      rstn = 1'b1;
      repeat (2) @(negedge sys_clk);
   endtask
   task automatic press();
      @(negedge sys_clk);
      readPress = 1'b1;
      @(negedge sys_clk);
      readPress = 1'b0;
   endtask
   task automatic busyWait(input int cycles);
      logic seen;
      seen = 1'b0;
      repeat (cycles)
      begin
         @(negedge sys_clk);
         seen = seen | chanRead | readAll | !running;
      end
      chk(16'(seen), 16'h0000);
   endtask
   task automatic expRead(input logic [7:0] ch, input logic all, output int cnt);
      cnt = 0;
      while (!(chanRead === 1'b1 || readAll === 1'b1) && cnt < 400)
      begin
         @(negedge sys_clk);
         cnt++;
      end
      chk(16'(cnt < 400), 16'h0001);
      chk(16'(readAll), 16'(all));
      if (!all)
         chk(16'(chanId), 16'(ch));
      if (hold > 0)
         busyWait(hold);
      gageDone = 1'b1;
      @(negedge sys_clk);
      gageDone = 1'b0;
   endtask
   task automatic quiet(input int cycles);
      logic seen;
      seen = 1'b0;
      repeat (cycles)
      begin
         @(negedge sys_clk);
         seen = seen | running | chanRead | readAll;
      end
      chk(16'(seen), 16'h0000);
   endtask
   task automatic readBack(input string s);
      int w;
      host.got.delete();
      host.sendStr("<UR", 1'b0);
      w = 0;
      while (!(host.got.size() > 0 && host.got[$] === user_cmd_pkg::CHAR_CR) && w < 3000)
      begin
         @(negedge sys_clk);
         w++;
      end
      chk(16'(host.got.size()), 16'(s.len() + 1));
      for (int i = 0; i < s.len() && i < host.got.size(); i++)
         chk(16'(host.got[i]), 16'(s[i]));
   endtask
   task automatic testParts();
      host.sendStr("<US<RA<RA,<RB", 1'b1);
      readBack("<RA<RA,<RB");
      press();
      press();
      expRead(8'h41, 1'b0, n);
      expRead(8'h41, 1'b0, n);
      quiet(30);
      press();
      expRead(8'h42, 1'b0, n);
      quiet(10);
      press();
      expRead(8'h41, 1'b0, n);
      expRead(8'h41, 1'b0, n);
      $display("test parts done");
   endtask
   task automatic testRefuse();
      readMode = user_cmd_pkg::MODE_STEP;
      press();
      quiet(30);
      readMode = user_cmd_pkg::MODE_MANUAL;
      press();
      quiet(30);
      readMode = user_cmd_pkg::MODE_AUTO;
      userCmdEnable = 1'b0;
      press();
      quiet(30);
      userCmdEnable = 1'b1;
      press();
      expRead(8'h42, 1'b0, n);
      $display("test refuse done");
   endtask
   task automatic testPause();
      host.sendStr("<US<Q2<R*", 1'b1);
      press();
      expRead(8'h00, 1'b1, n);
      chk(16'(n >= 2 * MS && n < 2 * MS + 40), 16'h0001);
      $display("test pause done");
   endtask
   task automatic testReset();
      doReset(1'b0);
      readBack("<Q2<R*");
      doReset(1'b1);
      readBack("");
      press();
      quiet(30);
      $display("test reset done");
   endtask
   task automatic testHold();
      host.sendStr("<US<RA<RC", 1'b1);
      press();
      clkEn = 1'b0;
      busyWait(20);
      clkEn = 1'b1;
      hold = 25;
      expRead(8'h41, 1'b0, n);
      hold = 0;
      expRead(8'h43, 1'b0, n);
      $display("test hold done");
   endtask
   task automatic testOverflow();
      string big;
      big = "";
      for (int i = 0; i < user_cmd_pkg::MAX_CHARS + 2; i++)
         big = {big, "x"};
      slow = 1'b1;
      host.sendStr({"<US", big}, 1'b1);
      readBack(big.substr(0, user_cmd_pkg::MAX_CHARS - 1));
      slow = 1'b0;
      $display("test overflow done");
   endtask
   initial
   begin
      rstn = 1'b0;
      clkEn = 1'b1;
      coldStart = 1'b1;
      userCmdEnable = 1'b1;
      readMode = user_cmd_pkg::MODE_AUTO;
      readPress = 1'b0;
      gageDone = 1'b0;
      slow = 1'b0;
      repeat (12) @(negedge sys_clk);
      rstn = 1'b1;
      repeat (2) @(negedge sys_clk);
      coldStart = 1'b0;
      testParts();
      testRefuse();
      testPause();
      testReset();
      testHold();
      testOverflow();
      test_done();
   end
   initial
   begin
      #40000;
      bad_count++;
      test_done();
   end
endmodule
